//--- shared/sltpg_pkg.sv
// Constants and types of the serial lane test pattern generator
// Function
// R1: In ramp mode the link layer runs normally while transport is off and formatter samples are dropped.
// R2: In ramp mode every lane sends the same octet count 0x00 to 0xFF, wrapping, once ILA is over.
// R3: The long transport pattern is offered only when the decimation factor is above 1.
// R4: The transport pattern follows the active output format (lane count, frame size, packing). The code ignores the lane count field.
// R5: Transport patterns of several devices start aligned to the SYSREF event after enabling.
// R6: Alternating-bit mode sends D21.5 on every lane without pause.
// R7: Comma mode sends K28.5 on every active lane without pause.
// R8: Repeated-ILA mode restarts the ILA sequence each time it ends instead of going to data.
// R9: In repeated-ILA mode each receiver sync request causes code group sync, then ILA resumes.
// R10: Entering repeated-ILA mode always starts with code group sync even with no request pending.
// R11: Modified RPAT mode repeats the twelve octets BE D7 23 47 6B 8F B3 14 5E FB 35 59.
// R12: The test pattern is picked by a four-bit lane test select field in bits 3:0 at index 0x202.
// R13: Software changes the lane test select only while the link enable is clear.
// R14: Lane power follows decimation and lane settings, never the selected test mode. The code uses only link enable and the lane count field, not decimation.
// R15: With select zero, normal sample data passes through with no pattern inserted.
package sltpg_pkg;
    localparam int ADDR_W = 14;
    localparam logic [11:0] IDX_LINK_CTRL = 12'h200;
    localparam logic [11:0] IDX_FORMAT = 12'h201;
    localparam logic [11:0] IDX_TEST = 12'h202;
    localparam logic [11:0] IDX_STATUS = 12'h203;
    localparam int LINK_EN_BIT = 0;
    localparam int TEST_LSB = 0;
    localparam int FMT_DEC_LSB = 0;
    localparam int FMT_PACK_BIT = 6;
    localparam int FMT_LANES_LSB = 8;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_SYNC_BIT = 4;
    localparam int ST_FULL_BIT = 5;
    localparam int ST_EMPTY_BIT = 6;
    localparam int ST_MODE_LSB = 8;
    localparam int ST_ILA_LSB = 12;
    localparam logic [3:0] TEST_RST = 4'h0;
    localparam logic [5:0] DEC_RST = 6'h04;
    localparam logic [2:0] LANES_RST = 3'h4;
    localparam logic PACK_RST = 1'b0;
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_RAMP = 4'h4;
    localparam logic [3:0] MODE_TRANSPORT = 4'h5;
    localparam logic [3:0] MODE_D21_5 = 4'h6;
    localparam logic [3:0] MODE_K28_5 = 4'h7;
    localparam logic [3:0] MODE_REP_ILA = 4'h8;
    localparam logic [3:0] MODE_RPAT = 4'h9;
    localparam logic [7:0] SYM_K28_5 = 8'hBC;
    localparam logic [7:0] SYM_D21_5 = 8'hB5;
    localparam logic [7:0] SYM_K28_0 = 8'h1C;
    localparam logic [7:0] SYM_K28_3 = 8'h7C;
    localparam logic [7:0] SYM_K28_4 = 8'h9C;
    localparam logic [3:0] RPAT_LAST = 4'hB;
    localparam logic [1:0] ILA_LAST_MF = 2'h3;
    localparam logic [15:0] TP_MARK = 16'h8000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CGS = 4'b0010,
        ST_ILA = 4'b0100,
        ST_DATA = 4'b1000
    } sltpg_state_t;

    typedef struct packed {
        logic k;
        logic [7:0] d;
    } sltpg_sym_t;

    typedef struct packed {
        logic [2:0] lanes;
        logic pack;
        logic [5:0] decim;
    } sltpg_fmt_t;

    function automatic logic [7:0] rpat_octet(input logic [3:0] i);
        case (i)
            4'h0: rpat_octet = 8'hBE;
            4'h1: rpat_octet = 8'hD7;
            4'h2: rpat_octet = 8'h23;
            4'h3: rpat_octet = 8'h47;
            4'h4: rpat_octet = 8'h6B;
            4'h5: rpat_octet = 8'h8F;
            4'h6: rpat_octet = 8'hB3;
            4'h7: rpat_octet = 8'h14;
            4'h8: rpat_octet = 8'h5E;
            4'h9: rpat_octet = 8'hFB;
            4'hA: rpat_octet = 8'h35;
            default: rpat_octet = 8'h59;
        endcase
    endfunction
endpackage

//--- hw/sltpg_top.sv
// Lane test pattern generator with APB registers and sample FIFO
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns

module sltpg_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic full,
    output logic empty
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0] wr_r;
    logic [PW:0] rd_r;
    logic push;
    logic pop;

    assign empty = (wr_r == rd_r);
    assign full = (wr_r[PW-1:0] == rd_r[PW-1:0]) && (wr_r[PW] != rd_r[PW]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_r[PW-1:0]];
    assign push = in_valid && !full;
    assign pop = out_ready && !empty;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_r[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
        end
    end
endmodule // sltpg_fifo

module sltpg_top
    import sltpg_pkg::*;
#(
    parameter int NUM_LANES = 4,
    parameter int FRAMES_PER_MF = 10,
    parameter int OCTETS_PER_FRAME = 2,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic [8*NUM_LANES-1:0] sample_data,
    input wire logic sync_n,
    input wire logic sysref,
    output sltpg_sym_t [NUM_LANES-1:0] lane_sym,
    output logic [NUM_LANES-1:0] lane_power_up
);
    localparam int MF_OCTETS = FRAMES_PER_MF * OCTETS_PER_FRAME;
    localparam int MF_W = $clog2(MF_OCTETS);
    localparam logic [MF_W-1:0] MF_END = MF_W'(MF_OCTETS - 1);

    logic link_en_r;
    logic [3:0] test_sel_r;
    logic [3:0] mode_r;
    sltpg_fmt_t fmt_r;
    sltpg_state_t state_r;
    logic [1:0] sync_meta_r;
    logic [2:0] sysref_sh_r;
    logic synced;
    logic sysref_edge;
    logic [MF_W-1:0] mf_oct_r;
    logic lmfc_end;
    logic [1:0] ila_mf_r;
    logic [7:0] ramp_r;
    logic [3:0] rpat_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic wr_en;
    logic [11:0] idx;
    logic fifo_ovalid;
    logic fifo_oready;
    logic [8*NUM_LANES-1:0] fifo_odata;
    logic fifo_full;
    logic fifo_empty;
    logic tp_ok;
    sltpg_sym_t [NUM_LANES-1:0] sym_nxt;
    sltpg_sym_t [NUM_LANES-1:0] lane_sym_r;

    // Lanes in use from the lane count field, zero means one
    function automatic logic [NUM_LANES-1:0] lane_mask(input logic [2:0] n);
        logic [NUM_LANES-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_LANES; i++) begin
            m[i] = (i < int'(n)) || (i == 0);
        end
        return m;
    endfunction

    // Transport pattern word for one lane and frame of the multiframe
    function automatic logic [15:0] tp_word(input int lane, input int frame, input logic pk);
        logic [15:0] w;
        w = '0;
        if (frame == 0) begin
            w = 16'(lane + 1) + 16'(pk);
        end else if (frame == 1) begin
            w = 16'(lane + 2);
        end else begin
            w = TP_MARK | 16'(frame - 2 == lane);
        end
        return w;
    endfunction

    assign idx = paddr[ADDR_W-1:2];
    assign wr_en = psel && penable && pwrite;
    assign pready = psel && penable;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign lane_sym = lane_sym_r;
    assign synced = sync_meta_r[1];
    assign sysref_edge = sysref_sh_r[1] && !sysref_sh_r[2];
    assign lmfc_end = (mf_oct_r == MF_END);
    assign tp_ok = (fmt_r.decim > 6'h01); // R3

    // Lane power ignores the test selection
    assign lane_power_up = link_en_r ? lane_mask(fmt_r.lanes) : '0; // R14

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            link_en_r <= 1'b0;
            test_sel_r <= TEST_RST;
            fmt_r <= '{lanes: LANES_RST, pack: PACK_RST, decim: DEC_RST};
        end else if (wr_en) begin
            case (idx)
                IDX_LINK_CTRL: link_en_r <= pwdata[LINK_EN_BIT];
                IDX_TEST: test_sel_r <= pwdata[TEST_LSB +: 4]; // R12
                IDX_FORMAT: begin
                    fmt_r.decim <= pwdata[FMT_DEC_LSB +: 6];
                    fmt_r.pack <= pwdata[FMT_PACK_BIT];
                    fmt_r.lanes <= pwdata[FMT_LANES_LSB +: 3];
                end
                default: ;
            endcase
        end
    end

    // Read data and error sampled in the setup cycle, held through access
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (psel && !penable) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            case (idx)
                IDX_LINK_CTRL: prdata_r[LINK_EN_BIT] <= link_en_r;
                IDX_TEST: prdata_r[TEST_LSB +: 4] <= test_sel_r;
                IDX_FORMAT: begin
                    prdata_r[FMT_DEC_LSB +: 6] <= fmt_r.decim;
                    prdata_r[FMT_PACK_BIT] <= fmt_r.pack;
                    prdata_r[FMT_LANES_LSB +: 3] <= fmt_r.lanes;
                end
                IDX_STATUS: begin
                    prdata_r[ST_STATE_LSB +: 4] <= state_r;
                    prdata_r[ST_SYNC_BIT] <= synced;
                    prdata_r[ST_FULL_BIT] <= fifo_full;
                    prdata_r[ST_EMPTY_BIT] <= fifo_empty;
                    prdata_r[ST_MODE_LSB +: 4] <= mode_r;
                    prdata_r[ST_ILA_LSB +: 2] <= ila_mf_r;
                end
                default: pslverr_r <= 1'b1;
            endcase
        end
    end

    // Selection frozen while the link runs so a mode never switches mid-link
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= TEST_RST;
        end else if (!link_en_r) begin
            mode_r <= test_sel_r; // R13
        end
    end

    // Pin inputs, two stages before use
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sync_meta_r <= 2'b00;
            sysref_sh_r <= 3'b000;
        end else begin
            sync_meta_r <= {sync_meta_r[0], sync_n};
            sysref_sh_r <= {sysref_sh_r[1:0], sysref};
        end
    end

    // Local multiframe clock, phase reset by SYSREF
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mf_oct_r <= '0;
        end else if (sysref_edge) begin
            mf_oct_r <= '0; // R5
        end else if (lmfc_end) begin
            mf_oct_r <= '0;
        end else begin
            mf_oct_r <= mf_oct_r + 1'b1;
        end
    end

    // Link sequencing
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            ila_mf_r <= 2'h0;
        end else if (!link_en_r) begin
            state_r <= ST_IDLE;
            ila_mf_r <= 2'h0;
        end else begin
            case (state_r)
                ST_IDLE: state_r <= ST_CGS; // R10
                ST_CGS: begin
                    if (synced && lmfc_end) begin
                        state_r <= ST_ILA;
                        ila_mf_r <= 2'h0;
                    end
                end
                ST_ILA: begin
                    if (!synced) begin
                        state_r <= ST_CGS; // R9
                    end else if (lmfc_end) begin
                        ila_mf_r <= ila_mf_r + 1'b1;
                        if (ila_mf_r == ILA_LAST_MF && mode_r != MODE_REP_ILA) begin
                            state_r <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (!synced) begin
                        state_r <= ST_CGS;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Ramp restarts at zero on the first data octet
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ramp_r <= 8'h00;
        end else if (state_r != ST_DATA) begin
            ramp_r <= 8'h00;
        end else begin
            ramp_r <= ramp_r + 8'h01; // R2
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rpat_r <= 4'h0;
        end else if (!link_en_r || rpat_r == RPAT_LAST) begin
            rpat_r <= 4'h0;
        end else begin
            rpat_r <= rpat_r + 4'h1; // R11
        end
    end

    // Test modes drain samples and drop them, except transport mode without tp_ok, which sends them; normal mode stalls outside data
    always_comb begin
        if (mode_r == MODE_NORMAL) begin
            fifo_oready = (state_r == ST_DATA); // R15
        end else begin
            fifo_oready = 1'b1; // R1
        end
    end

    sltpg_fifo #(
        .WIDTH(8 * NUM_LANES),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data(sample_data),
        .out_valid(fifo_ovalid),
        .out_ready(fifo_oready),
        .out_data(fifo_odata),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    always_comb begin
        logic [15:0] w;
        int frame;
        int oct;
        w = '0;
        frame = int'(mf_oct_r) / OCTETS_PER_FRAME;
        oct = int'(mf_oct_r) % OCTETS_PER_FRAME;
        for (int i = 0; i < NUM_LANES; i++) begin
            sym_nxt[i] = '{k: 1'b0, d: 8'h00};
            w = tp_word(i, frame, fmt_r.pack);
            if (!link_en_r) begin
                sym_nxt[i] = '{k: 1'b0, d: 8'h00};
            end else if (mode_r == MODE_D21_5) begin
                sym_nxt[i] = '{k: 1'b0, d: SYM_D21_5}; // R6
            end else if (mode_r == MODE_K28_5) begin
                sym_nxt[i] = '{k: 1'b1, d: SYM_K28_5}; // R7
            end else if (mode_r == MODE_RPAT) begin
                sym_nxt[i] = '{k: 1'b0, d: rpat_octet(rpat_r)}; // R11
            end else if (state_r == ST_CGS) begin
                sym_nxt[i] = '{k: 1'b1, d: SYM_K28_5};
            end else if (state_r == ST_ILA) begin
                // ILA framing; repeated in R8 mode by the sequencer
                if (mf_oct_r == '0) begin
                    sym_nxt[i] = '{k: 1'b1, d: SYM_K28_0}; // R8
                end else if (lmfc_end) begin
                    sym_nxt[i] = '{k: 1'b1, d: SYM_K28_3};
                end else if (ila_mf_r == 2'h1 && mf_oct_r == MF_W'(1)) begin
                    sym_nxt[i] = '{k: 1'b1, d: SYM_K28_4};
                end else begin
                    sym_nxt[i] = '{k: 1'b0, d: 8'(mf_oct_r)};
                end
            end else if (state_r == ST_DATA) begin
                if (mode_r == MODE_RAMP) begin
                    sym_nxt[i] = '{k: 1'b0, d: ramp_r}; // R1
                end else if (mode_r == MODE_TRANSPORT && tp_ok) begin
                    // High byte first within each frame
                    sym_nxt[i] = '{k: 1'b0, d: oct[0] ? w[7:0] : w[15:8]}; // R4
                end else if (fifo_ovalid) begin
                    sym_nxt[i] = '{k: 1'b0, d: fifo_odata[8*i +: 8]}; // R15
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lane_sym_r <= '0;
        end else begin
            lane_sym_r <= sym_nxt;
        end
    end
endmodule // sltpg_top

//--- test/sltpg_rx_model.sv
// Behavioural lane receiver that raises and drops the sync request
`timescale 1ns/1ns
module sltpg_rx_model
    import sltpg_pkg::*;
#(
    parameter int LOCK_CNT = 4
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire sltpg_sym_t rx_sym,
    input wire logic resync,
    input wire logic slow,
    output logic sync_n
);
    logic [7:0] cnt_r;
    logic [7:0] need;
    assign need = slow ? 8'(4 * LOCK_CNT) : 8'(LOCK_CNT);
    // Request stays low until enough commas in a row arrive
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 8'h00;
            sync_n <= 1'b0;
        end else if (resync) begin
            cnt_r <= 8'h00;
            sync_n <= 1'b0;
        end else if (!sync_n) begin
            cnt_r <= (rx_sym == {1'b1, SYM_K28_5}) ? cnt_r + 8'h01 : 8'h00;
            if (rx_sym == {1'b1, SYM_K28_5} && cnt_r == need - 8'h01) begin
                sync_n <= 1'b1;
            end
        end
    end
endmodule // sltpg_rx_model

//--- test/sltpg_monitor.sv
// Checker tying lane symbols to the programmed mode and lane power to link enable and lane count
`timescale 1ns/1ns
module sltpg_monitor
    import sltpg_pkg::*;
#(
    parameter int NUM_LANES = 4
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic sync_n,
    input wire sltpg_sym_t [NUM_LANES-1:0] lane_sym,
    input wire logic [NUM_LANES-1:0] lane_power_up
);
    localparam logic [8:0] K0 = {1'b1, SYM_K28_0};
    localparam logic [8:0] K3 = {1'b1, SYM_K28_3};
    localparam logic [8:0] K5 = {1'b1, SYM_K28_5};
    localparam logic [7:0] RP [12] = '{8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F,
        8'hB3, 8'h14, 8'h5E, 8'hFB, 8'h35, 8'h59};
    logic en_r, same, wr, link_m;
    logic [3:0] mode_r;
    logic [2:0] lanes_r;
    logic [NUM_LANES-1:0] pw_exp;
    assign wr = psel && penable && pwrite;
    assign link_m = !(mode_r inside {MODE_D21_5, MODE_K28_5, MODE_RPAT});
    function automatic logic [7:0] rp_next(input logic [7:0] d);
        rp_next = 8'h00;
        for (int i = 0; i < 12; i++) begin
            if (RP[i] == d) rp_next = RP[(i + 1) % 12];
        end
    endfunction
    // Mode only follows the select while the link is down
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            en_r <= 1'b0;
            mode_r <= TEST_RST;
            lanes_r <= LANES_RST;
        end else if (wr) begin
            if (paddr[ADDR_W-1:2] == IDX_LINK_CTRL) en_r <= pwdata[LINK_EN_BIT];
            if (paddr[ADDR_W-1:2] == IDX_TEST && !en_r) mode_r <= pwdata[3:0];
            if (paddr[ADDR_W-1:2] == IDX_FORMAT) lanes_r <= pwdata[10:8];
        end
    end
    always_comb begin
        same = 1'b1;
        for (int i = 0; i < NUM_LANES; i++) begin
            pw_exp[i] = en_r && (i < ((lanes_r == 3'h0) ? 1 : int'(lanes_r)));
            if (pw_exp[i] && lane_sym[i] != lane_sym[0]) same = 1'b0;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    a_power_map: assert property (lane_power_up == pw_exp)
        else $error("lane power differs from settings");
    a_off_quiet: assert property (!en_r && !$past(en_r) && !$past(en_r, 2) |-> lane_sym == '0)
        else $error("lanes active with link off");
    a_alt_stream: assert property (en_r && $past(en_r, 2) && mode_r == MODE_D21_5
        |-> same && lane_sym[0] == {1'b0, SYM_D21_5}) else $error("alternating stream broken");
    a_comma_stream: assert property (en_r && $past(en_r, 2) && mode_r == MODE_K28_5
        |-> same && lane_sym[0] == K5) else $error("comma stream broken");
    a_rpat_order: assert property (en_r && $past(en_r, 2) && mode_r == MODE_RPAT
        |-> same && lane_sym[0].d == rp_next($past(lane_sym[0].d))) else $error("rpat order wrong");
    a_ramp_step: assert property (en_r && $past(en_r, 2) && mode_r == MODE_RAMP &&
        !lane_sym[0].k && !$past(lane_sym[0].k) |-> lane_sym[0].d == $past(lane_sym[0].d) + 8'h01)
        else $error("ramp step wrong");
    a_ila_again: assert property (en_r && mode_r == MODE_REP_ILA && lane_sym[0] == K3
        |=> lane_sym[0] == K0 || lane_sym[0] == K5) else $error("ila not restarted");
    a_req_cgs: assert property ((en_r && link_m && !sync_n) [*6] |-> lane_sym[0] == K5)
        else $error("sync request without comma");
    a_entry_cgs: assert property ($rose(en_r) && mode_r == MODE_REP_ILA
        |-> ##[1:3] lane_sym[0] == K5) else $error("repeated ila entry without comma");
    c_rpat_wrap: cover property (en_r && mode_r == MODE_RPAT && lane_sym[0].d == 8'h59);
    c_ila_end: cover property (en_r && mode_r == MODE_REP_ILA && lane_sym[0] == K3);
    c_resync: cover property (en_r && $fell(sync_n));
endmodule // sltpg_monitor
bind sltpg_top sltpg_monitor #(.NUM_LANES(NUM_LANES)) u_sltpg_monitor (.ref_clk(ref_clk),
    .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .sync_n(sync_n), .lane_sym(lane_sym), .lane_power_up(lane_power_up));

//--- test/testbench.sv
// Self-checking bench of the lane test pattern generator
`timescale 1ns/1ns
module testbench;
    import sltpg_pkg::*;
    localparam logic [13:0] A_LINK = {IDX_LINK_CTRL, 2'b00};
    localparam logic [13:0] A_FMT = {IDX_FORMAT, 2'b00};
    localparam logic [13:0] A_TEST = {IDX_TEST, 2'b00};
    localparam logic [13:0] A_STAT = {IDX_STATUS, 2'b00};
    localparam logic [8:0] K3 = {1'b1, SYM_K28_3};
    localparam logic [8:0] K5 = {1'b1, SYM_K28_5};
    localparam logic [7:0] RP [12] = '{8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F,
        8'hB3, 8'h14, 8'h5E, 8'hFB, 8'h35, 8'h59};
    localparam logic [13:0] AD [5] = '{A_LINK, A_FMT, A_TEST, A_STAT, 14'h0FFC};
    localparam logic [31:0] EX [5] = '{32'h0000_0000, 32'h0000_0404, 32'h0000_0000,
        32'h0000_0041, 32'h0000_0000};
    localparam logic [3:0] CM [3] = '{MODE_D21_5, MODE_K28_5, MODE_RPAT};
    localparam logic [2:0] LN [3] = '{3'h4, 3'h2, 3'h0};
    logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, sample_valid, sample_ready;
    logic sync_n, sysref, resync, slow, feed, er;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, sample_data, rd;
    logic [3:0] lane_power_up, m;
    sltpg_sym_t [3:0] lane_sym;
    logic [31:0] q[$];
    int err_count, total_checks, cyc, i, j, k, n, na;
    sltpg_top u_sltpg_top (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_data(sample_data), .sync_n(sync_n), .sysref(sysref), .lane_sym(lane_sym),
        .lane_power_up(lane_power_up));
    sltpg_rx_model u_sltpg_rx_model (.ref_clk(ref_clk), .rstn(rstn), .rx_sym(lane_sym[0]),
        .resync(resync), .slow(slow), .sync_n(sync_n));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic end_of_test();
        if (err_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Hang guard at 50000 cycles, well above the under two thousand cycles the run needs
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            err_count++;
            end_of_test();
        end
    end
    always @(posedge ref_clk) begin
        if (feed) begin
            sample_valid <= ($urandom & 1) == 1;
            sample_data <= $urandom;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic start(input logic [3:0] md, input logic [31:0] f);
        apb(1'b1, A_LINK, 32'h0000_0000);
        apb(1'b1, A_FMT, f);
        apb(1'b1, A_TEST, {28'h000_0000, md});
        apb(1'b1, A_LINK, 32'h0000_0001);
        @(posedge ref_clk);
    endtask
    task automatic wait_sym(input logic [8:0] s, input int num, input int bound);
        int c;
        c = 0;
        for (int t = 0; t < bound && c < num; t++) begin
            @(negedge ref_clk);
            if (lane_sym[0] === s) c++;
        end
        chk(c, num);
    endtask
    function automatic logic [8:0] exp_sym(input logic [3:0] md, input int x);
        if (md == MODE_D21_5) return {1'b0, SYM_D21_5};
        if (md == MODE_K28_5) return {1'b1, SYM_K28_5};
        return {1'b0, RP[x % 12]};
    endfunction
    function automatic logic [7:0] tp_octet(input int ln, input int o);
        if (o == 1 || o == 3) return 8'(ln + 2);
        if (o == 4) return 8'h80;
        return (o == 5 && ln == 0) ? 8'h01 : 8'h00;
    endfunction
    initial begin
        void'($urandom(19));
        {rstn, psel, penable, pwrite, sample_valid, sysref, resync, slow, feed} = '0;
        paddr = 14'h0000;
        pwdata = 32'h0000_0000;
        sample_data = 32'h0000_0000;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        for (i = 0; i < 5; i++) begin
            apb(1'b0, AD[i], 32'h0000_0000);
            chk(rd, EX[i]);
            chk(er, i == 4);
        end
        apb(1'b1, A_TEST, 32'hFFFF_FFF9);
        apb(1'b0, A_TEST, 32'h0000_0000);
        chk(rd, 32'h0000_0009);
        apb(1'b1, A_TEST, 32'h0000_0000);
        // Buffer fills while the link is down
        sample_valid <= 1'b1;
        sample_data <= $urandom;
        for (i = 0; i < 14; i++) begin
            @(posedge ref_clk);
            if (sample_ready === 1'b1) begin
                q.push_back(sample_data);
                sample_data <= $urandom;
            end
        end
        sample_valid <= 1'b0;
        chk(q.size(), 8);
        apb(1'b0, A_STAT, 32'h0000_0000);
        chk(rd[ST_FULL_BIT], 1'b1);
        start(MODE_NORMAL, 32'h0000_0404);
        wait_sym(K3, 4, 2000);
        foreach (q[x]) begin
            @(negedge ref_clk);
            for (j = 0; j < 4; j++) chk(lane_sym[j], {1'b0, q[x][8*j +: 8]});
        end
        @(negedge ref_clk);
        chk(lane_sym[0], 9'h000);
        chk(lane_power_up, 4'hF);
        feed <= 1'b1;
        start(MODE_RAMP, 32'h0000_0404);
        wait_sym(K3, 4, 2000);
        for (n = 0; n < 300; n++) begin
            @(negedge ref_clk);
            for (j = 0; j < 4; j++) chk(lane_sym[j], {1'b0, 8'(n)});
            chk(sample_ready, 1'b1);
        end
        for (i = 0; i < 9; i++) begin
            m = CM[i % 3];
            start(m, {21'h00_0000, LN[i / 3], 8'h04});
            repeat (3) @(negedge ref_clk);
            na = (LN[i / 3] == 3'h0) ? 1 : int'(LN[i / 3]);
            chk(lane_power_up, (1 << na) - 1);
            for (k = 0; k < 12 && RP[k] !== lane_sym[0].d; k++);
            repeat (24) begin
                for (j = 0; j < na; j++) chk(lane_sym[j], exp_sym(m, k));
                k++;
                @(negedge ref_clk);
            end
        end
        feed <= 1'b0;
        sample_valid <= 1'b0;
        start(MODE_TRANSPORT, 32'h0000_0444);
        sysref <= 1'b1;
        @(posedge ref_clk);
        sysref <= 1'b0;
        wait_sym(K3, 4, 2000);
        for (n = 0; n < 6; n++) begin
            @(negedge ref_clk);
            for (j = 0; j < 4; j++) chk(lane_sym[j], {1'b0, tp_octet(j, n)});
        end
        start(MODE_TRANSPORT, 32'h0000_0401);
        wait_sym(K3, 4, 2000);
        repeat (4) begin
            @(negedge ref_clk);
            for (j = 0; j < 4; j++) chk(lane_sym[j], 9'h000);
        end
        slow <= 1'b1;
        start(MODE_REP_ILA, 32'h0000_0404);
        wait_sym(K5, 1, 4);
        wait_sym(K3, 8, 800);
        resync <= 1'b1;
        @(posedge ref_clk);
        resync <= 1'b0;
        wait_sym(K5, 1, 12);
        wait_sym(K3, 4, 800);
        end_of_test();
    end
endmodule // testbench
